// ### adcc_defines.svh
// constants for the eight-channel converter host controller
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
`define ADCC_CLK_PS 50000
`define ADCC_CYC_MIN(ps) (((ps) + `ADCC_CLK_PS - 1) / `ADCC_CLK_PS)
`define ADCC_CYC_MAX(ps) ((((ps) / `ADCC_CLK_PS) < 1) ? 1 : ((ps) / `ADCC_CLK_PS))
// pin-level timing in picoseconds
`define ADCC_T_CONV_LOW_PS 60000
`define ADCC_T_ACQ_PS 500000
`define ADCC_T_RD_GAP_PS 30000
`define ADCC_T_RD_LOW_PS 100000
`define ADCC_T_EOC_TMO_PS 1000000
`define ADCC_T_PWRUP_PS 1000000
`define ADCC_DISCARD 2
// register offsets (byte addresses)
`define ADCC_REG_CTRL 4'h0
`define ADCC_REG_STAT 4'h4
`define ADCC_REG_DATA 4'h8
// control field positions
`define ADCC_CTRL_GO 0
`define ADCC_CTRL_AUTOPD 1
`define ADCC_CTRL_CH_LO 4
`define ADCC_CTRL_CH_HI 6
`define ADCC_CTRL_RESYNC 8
// status field positions
`define ADCC_STAT_BUSY 0
`define ADCC_STAT_VALID 1
`define ADCC_STAT_PD 2
`define ADCC_STAT_DISC 3
`define ADCC_STAT_TMO 4
`define ADCC_STAT_CH_LO 8
`endif

// ### adcc_pkg.sv
// types shared by the converter host controller
`default_nettype none
package adcc_pkg;
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b000,
    ADCC_CONV = 3'b001,
    ADCC_WAIT = 3'b010,
    ADCC_READ = 3'b011,
    ADCC_GAP = 3'b100,
    ADCC_WAKE = 3'b101
  } adcc_state_e;
  typedef struct packed {
    logic convert_start_n;
    logic rd_n;
    logic cs_n;
    logic [2:0] channel_addr;
  } adcc_pins_s;
endpackage
`default_nettype wire

// ### adcc_host.sv
// host controller driving the eight-channel parallel converter
// Behaviour
// [RQ1] converter keeps done output high when idle; host waits for a low
// [RQ2] host starts each conversion with a falling convert-start edge
// [RQ3] host takes the falling done edge as end of conversion; code only notes the low and starts the read at the done rise
// [RQ4] converter powers up asleep; host assumes power-down after reset
// [RQ5] rising convert-start wakes converter; host gives it time to settle
// [RQ6] after resync request host discards two results
// [RQ7] result is unsigned straight binary, passed on unchanged
// [RQ8] code steps are one LSB; host does no scaling
// [RQ9] span chosen by converter supply detector; nothing for host
// [RQ10] three-bit address 0..7 selects channels one to eight
// [RQ11] converter starts on channel one; host address resets to zero
// [RQ12] channel kept across power-down; host need not re-send it
// [RQ13] address latched on read falling edge with chip select low
// [RQ14] host waits acquisition delay from read fall to next start
// [RQ15] hold of 120 ns is internal; start low covers it
// [RQ16] convert-start level at done rise picks the mode
// [RQ17] host always drives convert-start to a defined level
// [RQ18] auto power-down mode holds convert-start low past done
// [RQ19] low convert-start at sampling powers down; rising edge wakes
// [RQ20] fast mode: start returns high early; 30 ns after read
// [RQ21] done pulse ends within 110 ns or on read rise
// [RQ22] data read while chip select and read strobe are low
// [RQ23] data bus only sampled while converter drives it
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_host #(
  parameter int ACQ_CYC = `ADCC_CYC_MIN(`ADCC_T_ACQ_PS),
  parameter int PWRUP_CYC = `ADCC_CYC_MIN(`ADCC_T_PWRUP_PS),
  parameter int TMO_CYC = `ADCC_CYC_MAX(`ADCC_T_EOC_TMO_PS)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic convert_start_n,
  output logic rd_n,
  output logic cs_n,
  output logic [2:0] channel_addr,
  input wire logic eoc_n,
  input wire logic [7:0] adc_data
);
  localparam int CONV_LOW = `ADCC_CYC_MIN(`ADCC_T_CONV_LOW_PS);
  localparam int RD_LOW = `ADCC_CYC_MIN(`ADCC_T_RD_LOW_PS);
  localparam int GAP = `ADCC_CYC_MIN(`ADCC_T_RD_GAP_PS);
  localparam int CW = 10;

  initial begin
    if (ACQ_CYC < 1 || PWRUP_CYC < 1 || TMO_CYC < 1 ||
        ACQ_CYC >= 2 ** CW || PWRUP_CYC >= 2 ** CW || TMO_CYC >= 2 ** CW)
      $error("adcc_host: cycle counts out of range");
  end

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n);
  endfunction

  adcc_pkg::adcc_state_e state;
  adcc_pkg::adcc_pins_s pins;
  logic [CW-1:0] cnt;
  logic [CW-1:0] acq;
  logic autopd, powered_down, busy, valid, timeout, eoc_seen;
  logic [1:0] discard;
  logic [2:0] chan, next_chan;
  logic [7:0] result;
  logic go, wr_ctrl, rd_stat, rd_data;

  assign wr_ctrl = avs_write && !avs_waitrequest &&
                   avs_address == `ADCC_REG_CTRL;
  assign go = wr_ctrl && avs_writedata[`ADCC_CTRL_GO];
  // read side effects act at the edge that loads readdata, so a flag set
  // in that same cycle survives until the next read reports it
  assign rd_data = avs_read && avs_waitrequest &&
                   avs_address == `ADCC_REG_DATA;
  assign rd_stat = avs_read && avs_waitrequest &&
                   avs_address == `ADCC_REG_STAT;

  // bus slave: one wait cycle per access, so answers come on the 2nd edge
  always_ff @(posedge mclk) begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst)
      avs_readdata <= 32'h0;
    else if ((avs_read) && avs_waitrequest) begin
      unique case (avs_address)
        `ADCC_REG_CTRL: avs_readdata <= {24'h0, 1'b0, next_chan, 2'b00,
                                         autopd, 1'b0};
        `ADCC_REG_STAT: avs_readdata <= {21'h0, chan, 3'b000, timeout,
                                         discard != 2'b00, powered_down,
                                         valid, busy};
        `ADCC_REG_DATA: avs_readdata <= {24'h0, result}; // [RQ7] [RQ8] [RQ9]
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // control settings; new channel only reaches pins on the next read
  always_ff @(posedge mclk) begin
    if (rst) begin
      autopd <= 1'b0;
      next_chan <= 3'h0; // [RQ11]
    end else if (wr_ctrl) begin
      autopd <= avs_writedata[`ADCC_CTRL_AUTOPD];
      next_chan <= avs_writedata[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO]; // [RQ10]
    end
  end

  // conversion sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= adcc_pkg::ADCC_WAKE;
      // start held low in reset, so leaving it gives the waking rise
      pins <= '{convert_start_n: 1'b0, rd_n: 1'b1, cs_n: 1'b1,
                channel_addr: 3'h0}; // [RQ17] [RQ5]
      cnt <= cyc(PWRUP_CYC);
      powered_down <= 1'b1; // [RQ4]
      busy <= 1'b0;
      timeout <= 1'b0;
      eoc_seen <= 1'b0;
      chan <= 3'h0; // [RQ11]
      result <= 8'h00;
    end else begin
      if (rd_stat)
        timeout <= 1'b0;
      if (cnt != '0)
        cnt <= cnt - 1'b1;
      unique case (state)
        adcc_pkg::ADCC_WAKE: begin
          // wake via rising edge and wait for the analog side to settle
          pins.convert_start_n <= 1'b1; // [RQ5]
          if (cnt == '0) begin
            powered_down <= 1'b0;
            state <= adcc_pkg::ADCC_IDLE;
          end
        end
        adcc_pkg::ADCC_IDLE: begin
          if (go && acq == '0) begin
            pins.convert_start_n <= 1'b0; // [RQ2] [RQ15]
            busy <= 1'b1;
            eoc_seen <= 1'b0;
            cnt <= cyc(CONV_LOW);
            state <= adcc_pkg::ADCC_CONV;
          end
        end
        adcc_pkg::ADCC_CONV: begin
          // fast mode releases start before the end of conversion
          if (cnt == '0) begin
            if (!autopd)
              pins.convert_start_n <= 1'b1; // [RQ20] [RQ16]
            cnt <= cyc(TMO_CYC);
            state <= adcc_pkg::ADCC_WAIT;
          end
        end
        adcc_pkg::ADCC_WAIT: begin
          if (!eoc_n) // [RQ1] [RQ3]
            eoc_seen <= 1'b1;
          // auto power-down: start stays low through the done rise
          if (eoc_seen && eoc_n) begin // [RQ18] [RQ19]
            powered_down <= autopd;
            pins.cs_n <= 1'b0;
            pins.rd_n <= 1'b0; // [RQ13]
            pins.channel_addr <= next_chan;
            cnt <= cyc(RD_LOW);
            state <= adcc_pkg::ADCC_READ;
          end else if (cnt == '0) begin
            timeout <= 1'b1;
            busy <= 1'b0;
            pins.convert_start_n <= 1'b1;
            cnt <= cyc(PWRUP_CYC);
            powered_down <= 1'b1;
            state <= adcc_pkg::ADCC_WAKE;
          end
        end
        adcc_pkg::ADCC_READ: begin
          // reads work while powered down; data valid during strobe
          if (cnt == '0) begin
            result <= adc_data; // [RQ22] [RQ23]
            chan <= pins.channel_addr; // [RQ12]
            pins.rd_n <= 1'b1; // [RQ21]
            pins.cs_n <= 1'b1;
            cnt <= cyc(GAP);
            state <= adcc_pkg::ADCC_GAP;
          end
        end
        adcc_pkg::ADCC_GAP: begin
          if (cnt == '0) begin
            busy <= 1'b0;
            if (autopd) begin
              pins.convert_start_n <= 1'b1; // [RQ5]
              cnt <= cyc(PWRUP_CYC);
              state <= adcc_pkg::ADCC_WAKE;
            end else
              state <= adcc_pkg::ADCC_IDLE; // [RQ20]
          end
        end
        default: state <= adcc_pkg::ADCC_WAKE;
      endcase
    end
  end

  // acquisition timer from read fall to the next start
  always_ff @(posedge mclk) begin
    if (rst)
      acq <= '0;
    else if (state == adcc_pkg::ADCC_WAIT && eoc_seen && eoc_n)
      acq <= cyc(ACQ_CYC); // [RQ14]
    else if (acq != '0)
      acq <= acq - 1'b1;
  end

  // result validity and discard after resync
  always_ff @(posedge mclk) begin
    if (rst) begin
      valid <= 1'b0;
      discard <= 2'(`ADCC_DISCARD);
    end else begin
      if (state == adcc_pkg::ADCC_READ && cnt == '0) begin
        valid <= discard == 2'b00; // [RQ6]
        if (discard != 2'b00)
          discard <= discard - 1'b1;
      end else if (rd_data)
        valid <= 1'b0;
      if (wr_ctrl && avs_writedata[`ADCC_CTRL_RESYNC])
        discard <= 2'(`ADCC_DISCARD); // [RQ6]
    end
  end

  assign convert_start_n = pins.convert_start_n;
  assign rd_n = pins.rd_n;
  assign cs_n = pins.cs_n;
  assign channel_addr = pins.channel_addr;

  // checker helper: cycles since the last read strobe fall, saturating
  logic [CW-1:0] since_rd;
  always_ff @(posedge mclk) begin
    if (rst)
      since_rd <= '1;
    else if ($fell(rd_n))
      since_rd <= cyc(1);
    else if (since_rd != '1)
      since_rd <= since_rd + 1'b1;
  end

  chk_start_low: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
    $fell(convert_start_n) |-> busy [*2])
    else $error("start fell without busy");
  chk_read_addr: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
    $fell(rd_n) |-> !cs_n && channel_addr == $past(next_chan))
    else $error("read without chip select or address");
  chk_acq_wait: assert property (@(posedge mclk) disable iff (rst) // [RQ14]
    $fell(convert_start_n) |-> since_rd >= cyc(ACQ_CYC))
    else $error("start too soon after read");
  chk_wake_edge: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
    $fell(powered_down) |-> convert_start_n)
    else $error("woke without high start");
  chk_fast_release: assert property (@(posedge mclk) disable iff (rst) // [RQ20]
    (!autopd && $fell(rd_n)) |-> convert_start_n)
    else $error("fast mode start still low at read");
  chk_auto_hold: assert property (@(posedge mclk) disable iff (rst) // [RQ18]
    (autopd && $fell(rd_n)) |-> !convert_start_n)
    else $error("auto mode start released early");
  chk_read_pulse: assert property (@(posedge mclk) disable iff (rst) // [RQ21]
    $fell(rd_n) |-> !rd_n [*3] ##1 rd_n)
    else $error("read strobe wrong length");
  chk_strobes_pair: assert property (@(posedge mclk) disable iff (rst) // [RQ22]
    !rd_n |-> !cs_n)
    else $error("read strobe without chip select");
  cov_fast: cover property (@(posedge mclk) !autopd && $rose(rd_n));
  cov_auto: cover property (@(posedge mclk) autopd && $rose(rd_n));
  cov_timeout: cover property (@(posedge mclk) $rose(timeout));
endmodule
`default_nettype wire

// ### adcc_conv_model.sv
// behavioural model of the eight-channel converter for the host bench
`timescale 1ns/100ps
`default_nettype none
module adcc_conv_model #(
  parameter int CONV_CYC = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mute,
  input wire logic convert_start_n,
  input wire logic rd_n,
  input wire logic cs_n,
  input wire logic [2:0] channel_addr,
  output logic eoc_n,
  output logic [7:0] adc_data,
  output logic pd,
  output int viol
);
  logic start_q;
  logic rd_q;
  logic [2:0] chan;
  logic [7:0] result;
  int cnt;
  int acq;
  // no pull on the bus, so a released bus shows the inverse, not the result
  assign adc_data = (!cs_n && !rd_n) ? result : ~result;
  // pins sampled on the bench clock; the real part has no clock pin
  always @(posedge mclk) begin
    start_q <= convert_start_n;
    rd_q <= rd_n;
    acq <= acq + 1;
    if (rst) begin
      // supply applied: asleep, done idle, channel one
      pd <= 1'b1;
      chan <= 3'h0;
      cnt <= 0;
      acq <= 100;
      eoc_n <= 1'b1;
      viol <= 0;
    end else begin
      // falling start holds and converts the latched channel
      if (start_q && !convert_start_n) begin
        cnt <= CONV_CYC;
        result <= {chan, 5'h0b}; // straight binary code
        // a start while still asleep is a host fault too
        if (acq < 2 || pd) viol <= viol + 1;
      end
      if (!start_q && convert_start_n) pd <= 1'b0; // wake, channel kept
      if (cnt == 1 && !mute) eoc_n <= 1'b0;
      if (cnt > 0) cnt <= cnt - 1;
      // one-cycle done pulse; start level at its rise picks the mode
      if (!eoc_n) begin
        eoc_n <= 1'b1;
        pd <= !convert_start_n;
      end
      if (rd_q && !rd_n && !cs_n) begin
        chan <= channel_addr;
        acq <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the converter host controller
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.svh"
module testbench;
  logic mclk = 0;
  logic rst = 1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic convert_start_n;
  logic rd_n;
  logic cs_n;
  logic [2:0] channel_addr;
  logic eoc_n;
  logic [7:0] adc_data;
  logic pd;
  logic mute = 0;
  logic tmo_seen;
  logic [2:0] prev;
  logic [31:0] rdata;
  int viol;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int pd_cnt = 0;
  int n0;
  adcc_host #(.ACQ_CYC(2), .PWRUP_CYC(2), .TMO_CYC(20)) u_adcc_host (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .convert_start_n(convert_start_n), .rd_n(rd_n), .cs_n(cs_n),
    .channel_addr(channel_addr), .eoc_n(eoc_n), .adc_data(adc_data));
  adcc_conv_model u_adcc_conv_model (
    .mclk(mclk), .rst(rst), .mute(mute), .convert_start_n(convert_start_n),
    .rd_n(rd_n), .cs_n(cs_n), .channel_addr(channel_addr), .eoc_n(eoc_n),
    .adc_data(adc_data), .pd(pd), .viol(viol));
  always #25 mclk = ~mclk;
  // cycle ceiling; also counts cycles the converter spends asleep
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    pd_cnt <= pd_cnt + int'(pd);
    if (cyc == 40000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  // poll until neither busy nor asleep; a timeout flag is cleared on read
  task automatic wait_idle;
    tmo_seen = 1'b0;
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, `ADCC_REG_STAT, 32'h0);
      tmo_seen = tmo_seen | rdata[4];
      if (rdata[0] === 1'b0 && rdata[2] === 1'b0) break;
    end
    check({rdata[2], rdata[0]}, 2'b00);
  endtask
  // one conversion; the result carries the channel latched at the last read
  task automatic conv(input logic ap, input logic [2:0] ch, input logic rs,
                      input logic v);
    bus(1'b1, `ADCC_REG_CTRL,
        (32'(rs) << 8) | (32'(ch) << 4) | (32'(ap) << 1) | 32'h1);
    bus(1'b0, `ADCC_REG_STAT, 32'h0);
    check(rdata[0], 1'b1);
    wait_idle;
    check({rdata[10:8], rdata[1]}, {ch, v});
    bus(1'b0, `ADCC_REG_DATA, 32'h0);
    check(rdata[7:0], {prev, 5'h0b});
    prev = ch;
  endtask
  initial begin
    prev = 3'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // settled pins after the first edge out of reset: start has risen
    @(negedge mclk);
    check({convert_start_n, rd_n, cs_n, eoc_n}, 4'hf);
    @(posedge mclk);
    bus(1'b0, 4'hc, 32'h0);
    check(rdata, 32'h0);
    wait_idle;
    check(pd, 1'b0);
    conv(1'b0, 3'h0, 1'b0, 1'b0);
    n0 = pd_cnt;
    // fast mode walks every address; the first two results are discarded
    for (int k = 1; k < 8; k++) conv(1'b0, 3'(k), 1'b0, k >= 2);
    check(pd_cnt == n0, 1'b1);
    conv(1'b1, 3'h3, 1'b0, 1'b1);
    check(pd_cnt > n0, 1'b1);
    bus(1'b0, `ADCC_REG_CTRL, 32'h0);
    check(rdata, 32'h32);
    conv(1'b0, 3'h5, 1'b0, 1'b1);
    conv(1'b0, 3'h2, 1'b1, 1'b0);
    bus(1'b0, `ADCC_REG_STAT, 32'h0);
    check(rdata[3], 1'b1);
    conv(1'b0, 3'h6, 1'b0, 1'b0);
    conv(1'b0, 3'h1, 1'b0, 1'b1);
    // a converter that never signals done must end in a timeout
    mute <= 1'b1;
    bus(1'b1, `ADCC_REG_CTRL, 32'h1);
    wait_idle;
    check(tmo_seen, 1'b1);
    bus(1'b0, `ADCC_REG_STAT, 32'h0);
    check(rdata[4], 1'b0);
    check(viol, 0);
    report_and_stop;
  end
endmodule
`default_nettype wire
